// File: design/failsafe_regs.vh
`ifndef FAILSAFE_REGS_VH
`define FAILSAFE_REGS_VH
// Functional notes
// - after reset control register is zero except mode bit 17 set (halt)
// - mode field bits 17:16 decode 00 off, 01 retry, 10 halt, 11 skip
// - off mode waits forever, never flags a fail-safe error or its interrupt
// - retry mode reissues the same local transfer when the timer expires
// - halt mode target-aborts all later transfers until interrupt cleared
// - skip mode drops current transfer and proceeds with the next one
// - timer count register reads live 16-bit count, reset 8400h
// - timer preload register is read/write, reset 8400h, loads the timer
// - discard count register reads live 16-bit count, reset 0000h
// - discard preload register is read/write, reset zero
// - 32-bit scratch register, zero after reset, no side effect
// - writing one to command bit 1 clears the fail-safe interrupt
// - autoclear (bit 18) clears interrupt on read of global activity upper word
// - writing one to command core-reset bit resets the protocol core
// - error when core handshake misses the programmable interval after request
// - interrupt raised on error when enable set and mode not off
// - discard timer expiry during pending delayed read sets bit 23 status

`define OFF_GLOBAL    12'h800
`define OFF_CONTROL   12'h804
`define OFF_FS_COUNT  12'h808
`define OFF_FS_PRE    12'h80C
`define OFF_DC_COUNT  12'h810
`define OFF_DC_PRE    12'h814
`define OFF_SCRATCH   12'h818
`define OFF_COMMAND   12'h81C

`define CTRL_RESET    32'h0002_0000
`define CTRL_MASK     32'hFFFF_0000
`define TIMER_RESET   16'h8400
`define DISCARD_RESET 16'h0000
`define GLOBAL_FIXED  32'h0100_0000

`define BIT_DRR_HOLD  31
`define BIT_CORE_IE   21
`define BIT_DISC_IE   20
`define BIT_FS_IE     19
`define BIT_AUTOCLR   18
`define MODE_HI       17
`define MODE_LO       16
`define BIT_DISCARD   23
`define BIT_FS_ERR    22
`define BIT_INT_ACT   31
`define BIT_CORE_INT  16
`define CMD_CLEAR     1
`define CMD_CORE_RST  0

`define MODE_OFF      2'b00
`define MODE_RETRY    2'b01
`define MODE_HALT     2'b10
`define MODE_SKIP     2'b11
`endif

// File: design/failsafe_bridge.v
`include "failsafe_regs.vh"

module failsafe_bridge #(
	parameter TW = 16
) (
	input  wire        i_mclk,
	input  wire        i_reset,
	input  wire        i_ce,
	// register access, one-cycle strobes
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	input  wire [11:0] i_reg_addr,
	input  wire [31:0] i_reg_wdata,
	output reg  [31:0] o_reg_rdata,
	output reg         o_reg_ack,
	// host-side transfer toward the core window
	input  wire        i_xfer_req,
	input  wire        i_xfer_delayed_rd,
	output wire        o_xfer_abort,
	output reg         o_xfer_done,
	output reg         o_xfer_skipped,
	// internal local bus to the protocol core
	output reg         o_core_strobe,
	input  wire        i_core_ack,
	input  wire        i_core_int,
	input  wire        i_master_retry,
	output reg         o_core_reset,
	output wire        o_irq
);
	localparam S_IDLE = 2'b00;
	localparam S_WAIT = 2'b01;

	reg [31:0]   control;
	reg [TW-1:0] fs_pre;
	reg [TW-1:0] fs_count;
	reg [TW-1:0] dc_pre;
	reg [TW-1:0] dc_count;
	reg [31:0]   scratch;
	reg          fs_err;
	reg          discard;
	reg          dc_run;
	reg [1:0]    state;
	reg [31:0]   next_rdata;

	wire [1:0] mode = control[`MODE_HI:`MODE_LO];
	wire wr_cmd = i_reg_wr && i_reg_addr == `OFF_COMMAND;
	wire clr_cmd = wr_cmd && i_reg_wdata[`CMD_CLEAR];
	wire clr_auto = i_reg_rd && i_reg_addr == `OFF_GLOBAL && control[`BIT_AUTOCLR];
	// timer reaching zero while waiting is the timeout
	wire timeout = state == S_WAIT && !i_core_ack && fs_count == {TW{1'b0}};
	wire fs_int = fs_err && control[`BIT_FS_IE];
	wire dc_int = discard && control[`BIT_DISC_IE];
	wire core_int = i_core_int && control[`BIT_CORE_IE];

	assign o_irq = fs_int | dc_int | core_int;
	wire halted = fs_err && mode == `MODE_HALT;
	// the transfer that timed out ends as skipped; only later ones are aborted
	assign o_xfer_abort = i_xfer_req && state == S_IDLE && halted && !o_xfer_skipped;

	always @* begin
		next_rdata = 32'h0000_0000;
		case (i_reg_addr)
		`OFF_GLOBAL: begin
			next_rdata = `GLOBAL_FIXED;
			next_rdata[`BIT_INT_ACT] = o_irq;
			next_rdata[`BIT_DISCARD] = discard;
			next_rdata[`BIT_FS_ERR] = fs_err;
			next_rdata[`BIT_CORE_INT] = i_core_int;
		end
		`OFF_CONTROL: next_rdata = control;
		`OFF_FS_COUNT: next_rdata[TW-1:0] = fs_count;
		`OFF_FS_PRE: next_rdata[TW-1:0] = fs_pre;
		`OFF_DC_COUNT: next_rdata[TW-1:0] = dc_count;
		`OFF_DC_PRE: next_rdata[TW-1:0] = dc_pre;
		`OFF_SCRATCH: next_rdata = scratch;
		default: next_rdata = 32'h0000_0000;
		endcase
	end

	// per-register write strobes
	wire          wr_control = i_reg_wr && i_reg_addr == `OFF_CONTROL;
	wire          wr_fs_pre  = i_reg_wr && i_reg_addr == `OFF_FS_PRE;
	wire          wr_dc_pre  = i_reg_wr && i_reg_addr == `OFF_DC_PRE;
	wire          wr_scratch = i_reg_wr && i_reg_addr == `OFF_SCRATCH;
	wire          fs_set     = timeout && mode != `MODE_OFF;
	wire          fs_clear   = clr_cmd || clr_auto;
	wire          dc_zero    = dc_count == {TW{1'b0}};
	wire          dc_armed   = dc_pre != {TW{1'b0}};
	wire          xfer_start = i_xfer_req && !halted;
	wire [TW-1:0] fs_dec     = fs_count - {{(TW-1){1'b0}}, 1'b1};
	wire [TW-1:0] dc_dec     = dc_count - {{(TW-1){1'b0}}, 1'b1};

	reg [31:0]   next_control;
	reg [TW-1:0] next_fs_pre;
	reg [TW-1:0] next_dc_pre;
	reg [31:0]   next_scratch;
	reg          next_fs_err;
	reg          next_discard;
	reg          next_dc_run;
	reg [TW-1:0] next_dc_count;
	reg [TW-1:0] next_fs_count;
	reg [1:0]    next_state;
	reg          next_strobe;
	reg          next_done;
	reg          next_skipped;
	reg          dc_start;
	reg          next_ack;
	reg          next_core_reset;

	// reserved low control bits dropped even if the host ignores them
	always @* begin
		next_control = control;
		next_fs_pre = fs_pre;
		next_dc_pre = dc_pre;
		next_scratch = scratch;
		if (wr_control)
			next_control = i_reg_wdata & `CTRL_MASK;
		if (wr_fs_pre)
			next_fs_pre = i_reg_wdata[TW-1:0];
		if (wr_dc_pre)
			next_dc_pre = i_reg_wdata[TW-1:0];
		if (wr_scratch)
			next_scratch = i_reg_wdata;
	end

	always @* begin
		next_ack = i_reg_wr | i_reg_rd;
		next_core_reset = wr_cmd && i_reg_wdata[`CMD_CORE_RST];
	end

	// set wins over a same-cycle clear so no timeout is lost
	always @* begin
		next_fs_err = fs_err;
		if (fs_set)
			next_fs_err = 1'b1;
		else if (fs_clear)
			next_fs_err = 1'b0;
	end

	// off mode parks at zero; retry keeps the strobe up and reloads
	always @* begin
		next_state = state;
		next_fs_count = fs_count;
		next_strobe = o_core_strobe;
		next_done = 1'b0;
		next_skipped = 1'b0;
		dc_start = 1'b0;
		case (state)
		S_IDLE: begin
			if (xfer_start) begin
				next_fs_count = fs_pre;
				next_strobe = 1'b1;
				next_state = S_WAIT;
			end
		end
		S_WAIT: begin
			if (i_core_ack) begin
				next_strobe = 1'b0;
				next_done = 1'b1;
				next_state = S_IDLE;
				dc_start = i_xfer_delayed_rd;
			end else if (timeout) begin
				case (mode)
				`MODE_RETRY: next_fs_count = fs_pre;
				`MODE_HALT, `MODE_SKIP: begin
					next_strobe = 1'b0;
					next_skipped = 1'b1;
					next_state = S_IDLE;
				end
				default: next_fs_count = fs_count;
				endcase
			end else begin
				next_fs_count = fs_dec;
			end
		end
		default: next_state = S_IDLE;
		endcase
	end

	// zero preload means never expire, the compliant default
	always @* begin
		next_dc_run = dc_run;
		next_dc_count = dc_count;
		next_discard = discard;
		if (dc_start) begin
			next_dc_run = 1'b1;
			next_dc_count = dc_pre;
		end
		if (dc_run) begin
			if (i_master_retry)
				next_dc_run = 1'b0;
			else if (dc_armed && dc_zero) begin
				next_dc_run = 1'b0;
				next_discard = 1'b1;
			end else if (!dc_zero)
				next_dc_count = dc_dec;
		end
	end

	// configuration registers
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			control <= `CTRL_RESET;
		end else if (i_ce) begin
			control <= next_control;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			fs_pre <= `TIMER_RESET;
		end else if (i_ce) begin
			fs_pre <= next_fs_pre;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			dc_pre <= `DISCARD_RESET;
		end else if (i_ce) begin
			dc_pre <= next_dc_pre;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			scratch <= 32'h0000_0000;
		end else if (i_ce) begin
			scratch <= next_scratch;
		end
	end

	// bus answer
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_ce && i_reg_rd) begin
			o_reg_rdata <= next_rdata;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_reg_ack <= 1'b0;
		end else if (i_ce) begin
			o_reg_ack <= next_ack;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_core_reset <= 1'b0;
		end else if (i_ce) begin
			o_core_reset <= next_core_reset;
		end
	end

	// fail-safe status
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			fs_err <= 1'b0;
		end else if (i_ce) begin
			fs_err <= next_fs_err;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			discard <= 1'b0;
		end else if (i_ce) begin
			discard <= next_discard;
		end
	end

	// transfer sequencer
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state <= S_IDLE;
		end else if (i_ce) begin
			state <= next_state;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			fs_count <= `TIMER_RESET;
		end else if (i_ce) begin
			fs_count <= next_fs_count;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_core_strobe <= 1'b0;
		end else if (i_ce) begin
			o_core_strobe <= next_strobe;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_xfer_done <= 1'b0;
		end else if (i_ce) begin
			o_xfer_done <= next_done;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_xfer_skipped <= 1'b0;
		end else if (i_ce) begin
			o_xfer_skipped <= next_skipped;
		end
	end

	// discard timer
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			dc_run <= 1'b0;
		end else if (i_ce) begin
			dc_run <= next_dc_run;
		end
	end

	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			dc_count <= `DISCARD_RESET;
		end else if (i_ce) begin
			dc_count <= next_dc_count;
		end
	end
endmodule

// File: tb/core_model.sv
module core_model (
	input  wire logic i_mclk,
	input  wire logic i_hang,
	input  wire logic i_strobe,
	output logic      o_ack = 1'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	// one-cycle answer a cycle after strobe; hang stalls it as long as held
	always @(posedge i_mclk) o_ack <= i_strobe && !o_ack && !i_hang;
endmodule

// File: tb/fs_chk.sv
module fs_chk (
	input wire logic i_mclk, i_reset, i_reg_wr, i_reg_rd, o_reg_ack, i_xfer_req, o_xfer_abort,
	input wire logic o_xfer_done, o_xfer_skipped, o_core_strobe, i_core_ack, o_core_reset, o_irq,
	input wire logic [11:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata
);
	logic [1:0] md;
	wire cmd = i_reg_wr && i_reg_addr == 12'h81C;
	always @(posedge i_mclk or posedge i_reset)
		if (i_reset) md <= 2'h2;
		else if (i_reg_wr && i_reg_addr == 12'h804) md <= i_reg_wdata[17:16];
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	sequence stall; o_core_strobe && !i_core_ack; endsequence
	sequence skip_go; $rose(o_core_strobe) && md == 2'h3; endsequence
	a_ack_follows: assert property (i_reg_wr || i_reg_rd |=> o_reg_ack)
		else $error("no ack");
	a_core_reset: assert property (cmd && i_reg_wdata[0] |=> o_core_reset)
		else $error("no core reset");
	a_clear_irq: assert property (cmd && i_reg_wdata[1] && !o_core_strobe |=> !o_irq)
		else $error("irq kept");
	a_off_quiet: assert property (md == 2'h0 |-> !o_xfer_skipped && !$rose(o_irq))
		else $error("off mode acted");
	a_retry_holds: assert property (((md == 2'h1) and stall) |=> o_core_strobe)
		else $error("retry dropped");
	a_abort_halt: assert property (o_xfer_abort |-> md == 2'h2 && i_xfer_req)
		else $error("bad abort");
	a_skip_bound: assert property (skip_go ##1 stall |-> ##[1:12] o_xfer_skipped)
		else $error("no skip");
	a_done_ack: assert property (o_core_strobe && i_core_ack |=> o_xfer_done && !o_core_strobe)
		else $error("no done");
endmodule
bind failsafe_bridge fs_chk chk_u (.*);

// File: tb/test_failsafe_bridge.sv
module test_failsafe_bridge;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk = 0, i_reset = 1, i_reg_wr = 0, i_reg_rd = 0, i_xfer_req = 0, hang = 1;
	logic [11:0] i_reg_addr = 0;
	logic [31:0] i_reg_wdata = 0;
	wire [31:0] o_reg_rdata;
	wire o_reg_ack, o_xfer_abort, o_xfer_done, o_xfer_skipped, o_core_strobe, ack, o_core_reset, o_irq;
	int error_cnt = 0, checked = 0, cyc = 0;
	failsafe_bridge dut_u (.i_mclk, .i_reset, .i_ce(1'h1), .i_reg_wr, .i_reg_rd, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata, .o_reg_ack, .i_xfer_req, .i_xfer_delayed_rd(1'h0),
		.o_xfer_abort, .o_xfer_done, .o_xfer_skipped, .o_core_strobe, .i_core_ack(ack),
		.i_core_int(1'h0), .i_master_retry(1'h0), .o_core_reset, .o_irq);
	core_model core_u (.i_mclk, .i_hang(hang), .i_strobe(o_core_strobe), .o_ack(ack));
	initial forever #25 i_mclk = ~i_mclk;
	always @(posedge i_mclk) if (++cyc > 3000) begin
		error_cnt++;
		end_sim;
	end
	task chk(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task tk(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		{i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {w, !w, a, d};
		tk(1);
		{i_reg_wr, i_reg_rd} = 2'h0;
		if (!w) chk(o_reg_rdata, d);
		tk(1);
	endtask
	// waits on done, skipped or abort; abort is seen after the first clock
	task xf(input logic [2:0] e);
		i_xfer_req = 1;
		for (int n = 0; n < 60 && {o_xfer_abort, o_xfer_skipped, o_xfer_done} === 3'h0; n++) tk(1);
		chk({o_xfer_abort, o_xfer_skipped, o_xfer_done}, e);
		i_xfer_req = 0;
		tk(2);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		tk(3);
		i_reset = 0;
		acc(0, 12'h804, 32'h20000);
		acc(0, 12'h808, 32'h8400);
		acc(0, 12'h80C, 32'h8400);
		acc(0, 12'h810, 32'h0);
		acc(0, 12'h814, 32'h0);
		acc(0, 12'h81C, 32'h0);
		acc(1, 12'h818, 32'hA5C30F96);
		acc(0, 12'h818, 32'hA5C30F96);
		acc(1, 12'h814, 32'h7);
		acc(0, 12'h814, 32'h7);
		acc(0, 12'hFFC, 32'h0);
		acc(1, 12'h80C, 32'h4);
		acc(1, 12'h804, 32'hA0000);
		xf(3'h2);
		chk(o_irq, 1'h1);
		xf(3'h4);
		acc(1, 12'h81C, 32'h2);
		chk(o_irq, 1'h0);
		hang = 0;
		xf(3'h1);
		hang = 1;
		acc(1, 12'h804, 32'hF0000);
		xf(3'h2);
		xf(3'h2);
		acc(0, 12'h800, 32'h81400000);
		chk(o_irq, 1'h0);
		acc(1, 12'h804, 32'h80000);
		i_xfer_req = 1;
		tk(30);
		chk({o_irq, o_xfer_skipped, o_core_strobe}, 3'h1);
		hang = 0;
		xf(3'h1);
		hang = 1;
		acc(1, 12'h804, 32'h90000);
		i_xfer_req = 1;
		tk(20);
		chk({o_irq, o_xfer_skipped, o_core_strobe}, 3'h5);
		hang = 0;
		xf(3'h1);
		acc(1, 12'h81C, 32'h3);
		chk(o_irq, 1'h0);
		end_sim;
	end
endmodule
